// ---- include/ptpsq_defs.svh ----
/*
 * Constants for the stamp calculator and egress stamp queue: register
 * indices, control field positions, reset values and stamp geometry.
 * Assumes inclusion by bare name from the package, the checker and the testbench.
 */
`ifndef PTPSQ_DEFS_SVH
`define PTPSQ_DEFS_SVH

// ----------------------------------------------------------------------
// register indices
// ----------------------------------------------------------------------
`define PTPSQ_ADDR_W        4
`define PTPSQ_IDX_WORD0     4'h0
`define PTPSQ_IDX_POP       4'h6
`define PTPSQ_IDX_ASYM      4'h7
`define PTPSQ_IDX_LOC_LAT   4'h8
`define PTPSQ_IDX_PATH      4'h9
`define PTPSQ_IDX_CTRL      4'hA

// ----------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------
`define PTPSQ_F_SIG_LO      0
`define PTPSQ_F_SIG_HI      4
`define PTPSQ_F_SHORT       5
`define PTPSQ_F_THR_LO      8
`define PTPSQ_F_THR_HI      11
`define PTPSQ_F_THR_ENA     12
`define PTPSQ_F_ADD_ASYM    13
`define PTPSQ_F_SUB_ASYM    14
`define PTPSQ_F_SER_ENA     15
`define PTPSQ_F_OVF_CLR     16
`define PTPSQ_F_LVL_LO      20
`define PTPSQ_F_LVL_HI      23
`define PTPSQ_F_OVF         31
`define PTPSQ_CTRL_RESET    32'h0000_0010

// ----------------------------------------------------------------------
// stamp geometry
// ----------------------------------------------------------------------
`define PTPSQ_SIG_BITS      128
`define PTPSQ_STAMP_BITS    80
`define PTPSQ_WORD_BITS     208
`define PTPSQ_WORD_BYTES    6'd26
`define PTPSQ_LONG_BYTES    5'd10
`define PTPSQ_SHORT_BYTES   5'd4
`define PTPSQ_MAX_SIG       5'd16
`define PTPSQ_NS_PER_SEC    32'h3B9A_CA00
`define PTPSQ_FLAGS_FULL    3'h7

`endif

// ---- include/ptpsq_pkg.sv ----
/*
 * Types for the stamp calculator and egress stamp queue.
 * Assumes ptpsq_defs.svh is on the include path.
 */
`include "ptpsq_defs.svh"

package ptpsq_pkg;

	typedef enum logic {
		PTPSQ_INGRESS,
		PTPSQ_EGRESS
	} ptpsq_dir_t;

	typedef enum logic {
		PTPSQ_CMD_STAMP,
		PTPSQ_CMD_CORR
	} ptpsq_cmd_t;

	// one frame's request from the analyzer pipeline
	typedef struct packed {
		ptpsq_dir_t  dir;
		logic        event_msg;
		ptpsq_cmd_t  cmd;
		logic        store;
		logic [47:0] raw_sec;
		logic [31:0] raw_ns;
		logic [31:0] var_lat;
		logic [63:0] corr_in;
		logic [`PTPSQ_SIG_BITS-1:0] signature;
	} ptpsq_calc_in_t;

	// answer handed to the rewriter
	typedef struct packed {
		ptpsq_cmd_t  cmd;
		logic [`PTPSQ_STAMP_BITS-1:0] stamp;
		logic [63:0] corr;
	} ptpsq_rw_out_t;

endpackage

// ---- verilog/ptpsq_top.sv ----
/*
 * Stamp calculator with rewriter output buffer and packed egress stamp
 * queue read through seven readout registers.
 * Assumes one clock, synchronous reset, and a register port driven by
 * logic on the same clock.
 */
`timescale 1ns/100ps
`default_nettype none

// Function
// - ingress: raw minus fixed and variable latency
// - egress: raw plus fixed and variable latency
// - output is stamp or 64-bit signed correction
// - only event messages are modified
// - link delay always added into correction
// - compute corrected ns and ns plus link
// - asymmetry is 32-bit signed, 16 fraction bits
// - add control adds sign-extended asymmetry
// - subtract control subtracts sign-extended asymmetry
// - shadow copies of latency, link, asymmetry
// - stamp queue only on egress path
// - event raised for each stored stamp
// - overflow signals, inhibits writes, keeps entries
// - store only configured signature bytes
// - entry shrinks to ten or four bytes
// - pack end-to-end, write at 26 bytes
// - word0 bit 31 empty, 16 data bits
// - reading seventh register pops one word
// - flush partial packing when reads empty queue
// - three-bit flags code stamps per set
// - threshold event and readable fill level
// - serial output enabled makes readouts invalid
module ptpsq_top #(
	parameter int DEPTH = 8
) (
	input  wire logic                     clock,
	input  wire logic                     reset_n,
	input  wire logic                     calc_valid,
	input  wire ptpsq_pkg::ptpsq_calc_in_t calc_in,
	output logic                          calc_ready,
	output logic                          rw_valid,
	output ptpsq_pkg::ptpsq_rw_out_t      rw_out,
	input  wire logic                     rw_ready,
	input  wire logic                     reg_rd,
	input  wire logic                     reg_wr,
	input  wire logic [`PTPSQ_ADDR_W-1:0] reg_addr,
	input  wire logic [31:0]              reg_wdata,
	output logic [31:0]                   reg_rdata,
	output logic                          stamp_stored_evt,
	output logic                          overflow_evt,
	output logic                          threshold_evt
);
	import ptpsq_pkg::*;

	localparam int LW = $clog2(DEPTH + 1);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int QW = `PTPSQ_WORD_BITS + 3;

	initial begin
		if (DEPTH < 2 || DEPTH > 15)
			$error("DEPTH must lie in 2..15");
	end

	// ------------------------------------------------------------------
	// software registers
	// ------------------------------------------------------------------
	logic [31:0] asym_reg, loc_lat_reg, path_reg, ctrl_reg;
	logic [31:0] asym_sh_reg, loc_lat_sh_reg, path_sh_reg;

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			asym_reg    <= 32'h0000_0000;
			loc_lat_reg <= 32'h0000_0000;
			path_reg    <= 32'h0000_0000;
			ctrl_reg    <= `PTPSQ_CTRL_RESET;
		end else if (reg_wr) begin
			case (reg_addr)
				`PTPSQ_IDX_ASYM:    asym_reg    <= reg_wdata;
				`PTPSQ_IDX_LOC_LAT: loc_lat_reg <= reg_wdata;
				`PTPSQ_IDX_PATH:    path_reg    <= reg_wdata;
				`PTPSQ_IDX_CTRL:    ctrl_reg    <= reg_wdata & 32'h0000_FFFF;
				default:            ;
			endcase
		end
	end

	logic [4:0] sig_bytes;
	logic       short_mode, add_asym, sub_asym, ser_ena, thr_ena;
	logic [3:0] thr_level;
	always_comb begin
		sig_bytes  = ctrl_reg[`PTPSQ_F_SIG_HI:`PTPSQ_F_SIG_LO];
		if (sig_bytes > `PTPSQ_MAX_SIG)
			sig_bytes = `PTPSQ_MAX_SIG;
		short_mode = ctrl_reg[`PTPSQ_F_SHORT];
		thr_level  = ctrl_reg[`PTPSQ_F_THR_HI:`PTPSQ_F_THR_LO];
		thr_ena    = ctrl_reg[`PTPSQ_F_THR_ENA];
		add_asym   = ctrl_reg[`PTPSQ_F_ADD_ASYM];
		sub_asym   = ctrl_reg[`PTPSQ_F_SUB_ASYM];
		ser_ena    = ctrl_reg[`PTPSQ_F_SER_ENA];
	end

	// ------------------------------------------------------------------
	// stage 1: active stamp
	// ------------------------------------------------------------------
	logic           s1_valid_reg;
	ptpsq_calc_in_t s1_in_reg;
	logic [47:0]    s1_sec_reg;
	logic [31:0]    s1_ns_reg;
	logic [1:0]     buf_cnt_reg;
	logic           take;

	// space is reserved for the word already in flight, so no answer
	// can ever arrive at a full buffer
	always_comb begin
		calc_ready = (buf_cnt_reg + {1'b0, s1_valid_reg}) < 2'h2;
		take       = calc_valid && calc_ready && calc_in.event_msg;
	end

	// shadows follow software only while no frame is in flight
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			asym_sh_reg    <= 32'h0000_0000;
			loc_lat_sh_reg <= 32'h0000_0000;
			path_sh_reg    <= 32'h0000_0000;
		end else if (!s1_valid_reg && !take) begin
			asym_sh_reg    <= asym_reg;
			loc_lat_sh_reg <= loc_lat_reg;
			path_sh_reg    <= path_reg;
		end
	end

	logic signed [34:0] ns_sum;
	logic [47:0]        sec_next;
	logic [31:0]        ns_next;
	always_comb begin
		if (calc_in.dir == PTPSQ_INGRESS)
			ns_sum = $signed({3'h0, calc_in.raw_ns})
				- $signed({3'h0, loc_lat_sh_reg})
				- $signed({3'h0, calc_in.var_lat});
		else
			ns_sum = $signed({3'h0, calc_in.raw_ns})
				+ $signed({3'h0, loc_lat_sh_reg})
				+ $signed({3'h0, calc_in.var_lat});
		sec_next = calc_in.raw_sec;
		ns_next  = ns_sum[31:0];
		// latencies are far below one second: one wrap at most
		if (ns_sum < 0) begin
			ns_next  = ns_sum[31:0] + `PTPSQ_NS_PER_SEC;
			sec_next = calc_in.raw_sec - 48'h0000_0000_0001;
		end else if (ns_sum >= $signed({3'h0, `PTPSQ_NS_PER_SEC})) begin
			ns_next  = ns_sum[31:0] - `PTPSQ_NS_PER_SEC;
			sec_next = calc_in.raw_sec + 48'h0000_0000_0001;
		end
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			s1_valid_reg <= 1'b0;
			s1_in_reg    <= '0;
			s1_sec_reg   <= 48'h0;
			s1_ns_reg    <= 32'h0;
		end else begin
			s1_valid_reg <= take;
			if (take) begin
				s1_in_reg  <= calc_in;
				s1_sec_reg <= sec_next;
				s1_ns_reg  <= ns_next;
			end
		end
	end

	// ------------------------------------------------------------------
	// stage 2: nanoseconds and correction
	// ------------------------------------------------------------------
	logic [63:0]   corrected_ns, corrected_ns_plus_link, corr_calc;
	logic [63:0]   asym_ext;
	logic [79:0]   sec_prod;
	ptpsq_rw_out_t s2_out;
	always_comb begin
		sec_prod = s1_sec_reg * `PTPSQ_NS_PER_SEC;
		corrected_ns = sec_prod[63:0] + {32'h0, s1_ns_reg};
		corrected_ns_plus_link = corrected_ns + {32'h0, path_sh_reg};
		asym_ext = {{32{asym_sh_reg[31]}}, asym_sh_reg};
		if (s1_in_reg.dir == PTPSQ_INGRESS)
			corr_calc = s1_in_reg.corr_in - {corrected_ns[47:0], 16'h0}
				+ {16'h0, path_sh_reg, 16'h0};
		else
			corr_calc = s1_in_reg.corr_in
				+ {corrected_ns_plus_link[47:0], 16'h0};
		if (add_asym)
			corr_calc = corr_calc + asym_ext;
		if (sub_asym)
			corr_calc = corr_calc - asym_ext;
		s2_out.cmd   = s1_in_reg.cmd;
		s2_out.stamp = {s1_sec_reg, s1_ns_reg};
		s2_out.corr  = (s1_in_reg.cmd == PTPSQ_CMD_CORR) ? corr_calc
			: s1_in_reg.corr_in;
	end

	// ------------------------------------------------------------------
	// two-entry rewriter buffer
	// ------------------------------------------------------------------
	ptpsq_rw_out_t buf_mem [2];
	logic          buf_rd_reg, buf_wr_reg;
	logic          buf_pop;
	assign buf_pop = rw_valid && rw_ready;

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			buf_cnt_reg <= 2'h0;
			buf_rd_reg  <= 1'b0;
			buf_wr_reg  <= 1'b0;
		end else begin
			buf_cnt_reg <= buf_cnt_reg + {1'b0, s1_valid_reg}
				- {1'b0, buf_pop};
			if (s1_valid_reg) begin
				buf_mem[buf_wr_reg] <= s2_out;
				buf_wr_reg <= ~buf_wr_reg;
			end
			if (buf_pop)
				buf_rd_reg <= ~buf_rd_reg;
		end
	end

	// head registered so the outputs leave straight from flip-flops
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			rw_valid <= 1'b0;
			rw_out   <= '0;
		end else if (!rw_valid || rw_ready) begin
			if (buf_cnt_reg - {1'b0, buf_pop} != 2'h0) begin
				rw_valid <= 1'b1;
				rw_out   <= buf_mem[buf_rd_reg ^ buf_pop];
			end else if (s1_valid_reg) begin
				rw_valid <= 1'b1;
				rw_out   <= s2_out;
			end else begin
				rw_valid <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------------
	// entry builder and packing register
	// ------------------------------------------------------------------
	logic        ovf_reg, store_req;
	logic [4:0]  stamp_bytes;
	logic [5:0]  entry_len;
	logic [`PTPSQ_WORD_BITS-1:0] entry, sig_mask, stamp_part;
	always_comb begin
		store_req = s1_valid_reg && s1_in_reg.store && !ovf_reg
			&& (s1_in_reg.dir == PTPSQ_EGRESS);
		stamp_bytes = short_mode ? `PTPSQ_SHORT_BYTES
			: `PTPSQ_LONG_BYTES;
		entry_len  = {1'b0, stamp_bytes} + {1'b0, sig_bytes};
		stamp_part = short_mode ? {176'h0, s1_ns_reg}
			: {128'h0, s1_sec_reg, s1_ns_reg};
		sig_mask = ~({`PTPSQ_WORD_BITS{1'b1}} << {sig_bytes, 3'h0});
		entry = stamp_part | (({80'h0, s1_in_reg.signature} & sig_mask)
			<< {stamp_bytes, 3'h0});
	end

	logic [2*`PTPSQ_WORD_BITS-1:0] pack_reg, pack_sum;
	logic [5:0] pack_cnt_reg;
	logic [6:0] sum_cnt;
	logic [2:0] starts_reg;
	logic       flush_pend_reg, q_full, q_empty;
	logic       q_wr, q_pop;
	logic [QW-1:0] q_wdata;

	always_comb begin
		pack_sum = pack_reg | ({208'h0, entry} << {pack_cnt_reg, 3'h0});
		sum_cnt  = {1'b0, pack_cnt_reg} + {1'b0, entry_len};
		q_wr     = 1'b0;
		q_wdata  = {starts_reg, pack_reg[`PTPSQ_WORD_BITS-1:0]};
		if (store_req && sum_cnt >= {1'b0, `PTPSQ_WORD_BYTES}) begin
			q_wr    = 1'b1;
			q_wdata = {`PTPSQ_FLAGS_FULL, pack_sum[`PTPSQ_WORD_BITS-1:0]};
		end else if (!store_req && flush_pend_reg && pack_cnt_reg != 6'h0)
			q_wr = 1'b1;
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			pack_reg     <= '0;
			pack_cnt_reg <= 6'h0;
			starts_reg   <= 3'h0;
		end else if (store_req) begin
			if (sum_cnt >= {1'b0, `PTPSQ_WORD_BYTES}) begin
				// the remainder continues a stamp begun in the word above
				pack_reg     <= pack_sum >> `PTPSQ_WORD_BITS;
				pack_cnt_reg <= 6'(sum_cnt - {1'b0, `PTPSQ_WORD_BYTES});
				starts_reg   <= 3'h0;
			end else begin
				pack_reg     <= pack_sum;
				pack_cnt_reg <= sum_cnt[5:0];
				starts_reg   <= starts_reg + 3'h1;
			end
		end else if (q_wr) begin
			pack_reg     <= '0;
			pack_cnt_reg <= 6'h0;
			starts_reg   <= 3'h0;
		end
	end

	// ------------------------------------------------------------------
	// stamp queue
	// ------------------------------------------------------------------
	logic [QW-1:0] q_mem [DEPTH];
	logic [PW-1:0] q_wp_reg, q_rp_reg;
	logic [LW-1:0] q_lvl_reg;
	logic          q_push;

	always_comb begin
		q_full  = q_lvl_reg == LW'(DEPTH);
		q_empty = q_lvl_reg == '0;
		q_push  = q_wr && !q_full;
		q_pop   = reg_rd && reg_addr == `PTPSQ_IDX_POP && !q_empty
			&& !ser_ena;
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			q_wp_reg  <= '0;
			q_rp_reg  <= '0;
			q_lvl_reg <= '0;
		end else begin
			if (q_push) begin
				q_mem[q_wp_reg] <= q_wdata;
				q_wp_reg <= (q_wp_reg == PW'(DEPTH - 1)) ? '0 : q_wp_reg + 1'b1;
			end
			if (q_pop)
				q_rp_reg <= (q_rp_reg == PW'(DEPTH - 1)) ? '0 : q_rp_reg + 1'b1;
			q_lvl_reg <= q_lvl_reg + LW'(q_push) - LW'(q_pop);
		end
	end

	// a pop that empties the queue requests a flush of the packing bytes
	always_ff @(posedge clock) begin
		if (!reset_n)
			flush_pend_reg <= 1'b0;
		else if (q_pop && q_lvl_reg == LW'(1) && !q_push)
			flush_pend_reg <= 1'b1;
		else if (q_push || (!store_req && pack_cnt_reg == 6'h0))
			flush_pend_reg <= 1'b0;
	end

	// overflow: set wins over software clear
	always_ff @(posedge clock) begin
		if (!reset_n)
			ovf_reg <= 1'b0;
		else if (q_wr && q_full)
			ovf_reg <= 1'b1;
		else if (reg_wr && reg_addr == `PTPSQ_IDX_CTRL
			&& reg_wdata[`PTPSQ_F_OVF_CLR])
			ovf_reg <= 1'b0;
	end

	// ------------------------------------------------------------------
	// events toward the cpu
	// ------------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			stamp_stored_evt <= 1'b0;
			overflow_evt     <= 1'b0;
			threshold_evt    <= 1'b0;
		end else begin
			stamp_stored_evt <= store_req;
			overflow_evt     <= q_wr && q_full;
			threshold_evt    <= thr_ena && thr_level != 4'h0
				&& 5'(q_lvl_reg) >= {1'b0, thr_level};
		end
	end

	// ------------------------------------------------------------------
	// register readback
	// ------------------------------------------------------------------
	logic [QW-1:0] head;
	logic [31:0]   rd_mux;
	logic [2:0]    ro_idx;
	assign head   = q_mem[q_rp_reg];
	assign ro_idx = reg_addr[2:0];

	always_comb begin
		rd_mux = 32'h0000_0000;
		case (reg_addr)
			`PTPSQ_IDX_ASYM:    rd_mux = asym_reg;
			`PTPSQ_IDX_LOC_LAT: rd_mux = loc_lat_reg;
			`PTPSQ_IDX_PATH:    rd_mux = path_reg;
			`PTPSQ_IDX_CTRL: begin
				rd_mux = ctrl_reg;
				rd_mux[`PTPSQ_F_LVL_HI:`PTPSQ_F_LVL_LO] = 4'(q_lvl_reg);
				rd_mux[`PTPSQ_F_OVF] = ovf_reg;
			end
			default: begin
				// invalid contents while the serial path owns the queue
				if (reg_addr <= `PTPSQ_IDX_POP && !ser_ena) begin
					if (ro_idx == 3'h0)
						rd_mux = {q_empty, head[QW-1:QW-3], 12'h000,
							head[15:0]};
					else
						rd_mux = head[32*ro_idx-16 +: 32];
				end else if (reg_addr == `PTPSQ_IDX_WORD0)
					rd_mux = {q_empty, 31'h0};
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (!reset_n)
			reg_rdata <= 32'h0000_0000;
		else if (reg_rd)
			reg_rdata <= rd_mux;
	end

endmodule

`default_nettype wire

// ---- verilog/ptpsq_unused_placeholder_removed.sv ----
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// ---- dv/ptpsq_top_sva.sv ----
/*
 * Checker for the stamp calculator and stamp queue ports.
 * Assumes one clock and the synchronous active-low reset of the top.
 */
`timescale 1ns/100ps
`default_nettype none
`include "ptpsq_defs.svh"

module ptpsq_top_chk #(
	parameter int DEPTH = 8
) (
	input wire logic                      clock,
	input wire logic                      reset_n,
	input wire logic                      calc_valid,
	input wire ptpsq_pkg::ptpsq_calc_in_t calc_in,
	input wire logic                      calc_ready,
	input wire logic                      rw_valid,
	input wire ptpsq_pkg::ptpsq_rw_out_t  rw_out,
	input wire logic                      rw_ready,
	input wire logic                      reg_rd,
	input wire logic                      reg_wr,
	input wire logic [`PTPSQ_ADDR_W-1:0]  reg_addr,
	input wire logic [31:0]               reg_wdata,
	input wire logic [31:0]               reg_rdata,
	input wire logic                      stamp_stored_evt,
	input wire logic                      overflow_evt,
	input wire logic                      threshold_evt
);
	import ptpsq_pkg::*;
	logic take, ser_on, thr_on, ovf_seen, ctrl_wr;
	assign take = calc_valid && calc_ready && calc_in.event_msg;
	assign ctrl_wr = reg_wr && reg_addr == `PTPSQ_IDX_CTRL;

	// ----------------------------------------------------------------
	// control mirror
	// ----------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			ser_on <= 1'b0;
			thr_on <= 1'b0;
		end else if (ctrl_wr) begin
			ser_on <= reg_wdata[`PTPSQ_F_SER_ENA];
			thr_on <= reg_wdata[12] && reg_wdata[11:8] != 4'h0;
		end
	end
	// set wins over clear, as in the design
	always_ff @(posedge clock) begin
		if (!reset_n)
			ovf_seen <= 1'b0;
		else if (overflow_evt)
			ovf_seen <= 1'b1;
		else if (ctrl_wr && reg_wdata[`PTPSQ_F_OVF_CLR])
			ovf_seen <= 1'b0;
	end

	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);

	chk_answer_latency: assert property (take && !rw_valid &&
		!$past(take) |-> ##2 rw_valid)
		else $error("answer late");
	chk_answer_holds: assert property (rw_valid && !rw_ready |=>
		rw_valid && $stable(rw_out))
		else $error("answer dropped while stalled");
	chk_nonevent_quiet: assert property (calc_valid && calc_ready &&
		!calc_in.event_msg && !rw_valid && !$past(take) |-> ##2 !rw_valid)
		else $error("answer for non-event");
	chk_corr_passthru: assert property (take && !rw_valid &&
		calc_in.cmd == PTPSQ_CMD_STAMP && !$past(take) |->
		##2 rw_out.corr == $past(calc_in.corr_in, 2))
		else $error("stamp command altered corr");
	chk_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
		else $error("read data moved");
	chk_ovf_single: assert property (overflow_evt |=> !overflow_evt)
		else $error("second drop while inhibited");
	chk_ovf_flag: assert property (reg_rd && ovf_seen &&
		reg_addr == `PTPSQ_IDX_CTRL |=> reg_rdata[`PTPSQ_F_OVF])
		else $error("overflow flag missing");
	chk_serial_blank: assert property (reg_rd && ser_on &&
		reg_addr >= 4'h1 && reg_addr <= `PTPSQ_IDX_POP |=> reg_rdata == 32'h0)
		else $error("readout valid with serial on");
	chk_thr_off: assert property (!thr_on && !$past(thr_on)
		|-> !threshold_evt)
		else $error("threshold event while disabled");
endmodule

bind ptpsq_top ptpsq_top_chk #(.DEPTH(DEPTH)) u_chk (
	.clock(clock), .reset_n(reset_n), .calc_valid(calc_valid),
	.calc_in(calc_in), .calc_ready(calc_ready), .rw_valid(rw_valid),
	.rw_out(rw_out), .rw_ready(rw_ready), .reg_rd(reg_rd),
	.reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_rdata(reg_rdata), .stamp_stored_evt(stamp_stored_evt),
	.overflow_evt(overflow_evt), .threshold_evt(threshold_evt)
);
`default_nettype wire

// ---- dv/ptpsq_rw_sink.sv ----
/*
 * Rewriter model: takes answers, optionally stalling every other cycle.
 * Assumes the design clock and synchronous active-low reset.
 */
`timescale 1ns/100ps
`default_nettype none

module ptpsq_rw_sink (
	input wire logic                     clock,
	input wire logic                     reset_n,
	input wire logic                     rw_valid,
	input wire ptpsq_pkg::ptpsq_rw_out_t rw_out,
	input wire logic                     slow,
	output logic                         rw_ready,
	output var int                       got_cnt,
	output ptpsq_pkg::ptpsq_rw_out_t     got_last
);
	import ptpsq_pkg::*;
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			rw_ready <= 1'b0;
			got_cnt <= 0;
			got_last <= '0;
		end else begin
			// stall pattern makes the output buffer fill up
			rw_ready <= slow ? ~rw_ready : 1'b1;
			if (rw_valid && rw_ready) begin
				got_cnt <= got_cnt + 1;
				got_last <= rw_out;
			end
		end
	end
endmodule
`default_nettype wire

// ---- dv/tb_ptpsq_top.sv ----
/*
 * Testbench: register and stamp request sequences with expected values.
 * Assumes the package, defines header and rewriter model are compiled.
 */
`timescale 1ns/100ps
`default_nettype none
`include "ptpsq_defs.svh"

module tb_ptpsq_top;
	import ptpsq_pkg::*;
	localparam logic [31:0]  LAT  = 32'd100;
	localparam logic [31:0]  ASYM = 32'hFFFF_8000;
	localparam logic [63:0]  SX   = {{32{ASYM[31]}}, ASYM};
	localparam logic [63:0]  C0   = 64'h0000_0000_0001_0000;
	logic                clock, reset_n, calc_valid, calc_ready, rw_valid;
	logic                rw_ready, reg_rd, reg_wr, slow, te;
	logic                stamp_stored_evt, overflow_evt, threshold_evt;
	logic [3:0]          reg_addr;
	logic [31:0]         reg_wdata, reg_rdata, rd, w;
	logic [223:0]        pk;
	ptpsq_calc_in_t      calc_in;
	ptpsq_rw_out_t       rw_out, got_last;
	int                  errors, cmp_count, st_n, ovf_n, n0, i, got_cnt;

	ptpsq_top #(.DEPTH(2)) u_dut (
		.clock(clock), .reset_n(reset_n), .calc_valid(calc_valid),
		.calc_in(calc_in), .calc_ready(calc_ready), .rw_valid(rw_valid),
		.rw_out(rw_out), .rw_ready(rw_ready), .reg_rd(reg_rd),
		.reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .stamp_stored_evt(stamp_stored_evt),
		.overflow_evt(overflow_evt), .threshold_evt(threshold_evt));
	ptpsq_rw_sink u_rw (
		.clock(clock), .reset_n(reset_n), .rw_valid(rw_valid),
		.rw_out(rw_out), .slow(slow), .rw_ready(rw_ready),
		.got_cnt(got_cnt), .got_last(got_last));

	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	always @(posedge clock) begin
		if (reset_n && stamp_stored_evt === 1'b1) st_n++;
		if (reset_n && overflow_evt === 1'b1) ovf_n++;
	end

	// ----------------------------------------------------------------
	// access tasks
	// ----------------------------------------------------------------
	task automatic chk_reg(input string n, input logic [31:0] e, g);
		cmp_count++;
		if (g !== e) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic chk_rw(input string n, input logic [79:0] e, g);
		cmp_count++;
		if (g !== e) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_wr <= 1'b0;
		@(posedge clock);
	endtask
	task automatic reg_read(input logic [3:0] a);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd <= 1'b0;
		#10 rd = reg_rdata;
		te = threshold_evt;
		@(posedge clock);
	endtask
	// holds the request until an edge that saw calc_ready high
	task automatic calc(input ptpsq_dir_t d, input logic ev,
		input ptpsq_cmd_t c, input logic st, input logic [31:0] ns);
		ptpsq_calc_in_t v;
		logic ok;
		v = '0;
		v.dir = d;
		v.event_msg = ev;
		v.cmd = c;
		v.store = st;
		v.raw_ns = ns;
		v.var_lat = 32'd20;
		v.corr_in = C0;
		v.signature = {4{32'hA5C3_0F1E}};
		calc_valid <= 1'b1;
		calc_in <= v;
		do begin
			#10 ok = calc_ready;
			@(posedge clock);
		end while (!ok);
		calc_valid <= 1'b0;
	endtask
	task automatic stamp_case(input ptpsq_dir_t d, input ptpsq_cmd_t c,
		input logic poke, input logic [79:0] es, input logic [63:0] ec);
		int k;
		k = 0;
		n0 = got_cnt;
		// a delay write on the take edge must not be seen
		fork
			calc(d, 1'b1, c, d == PTPSQ_INGRESS, 32'd1000);
			if (poke) reg_write(`PTPSQ_IDX_PATH, 32'd77);
		join
		while (got_cnt == n0 && k < 20) begin
			@(posedge clock);
			k++;
		end
		if (c == PTPSQ_CMD_STAMP) chk_rw("rw_stamp", es, got_last.stamp);
		chk_rw("rw_corr", {16'h0, ec}, {16'h0, got_last.corr});
		if (poke) reg_write(`PTPSQ_IDX_PATH, 32'd5);
	endtask
	task automatic end_of_test();
		if (errors == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	initial begin
		#2_000_000;
		errors++;
		end_of_test();
	end

	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial begin
		errors = 0; cmp_count = 0; st_n = 0; ovf_n = 0;
		reset_n = 1'b0; calc_valid = 1'b0; calc_in = '0; slow = 1'b0;
		reg_rd = 1'b0; reg_wr = 1'b0; reg_addr = 4'h0; reg_wdata = 32'h0;
		repeat (16) @(posedge clock);
		reset_n <= 1'b1;
		@(posedge clock);
		reg_read(`PTPSQ_IDX_CTRL);
		chk_reg("ctrl_reset", `PTPSQ_CTRL_RESET, rd);
		reg_read(`PTPSQ_IDX_WORD0);
		chk_reg("empty_bit", 32'h1, {31'h0, rd[31]});
		reg_read(4'hF);
		chk_reg("unmapped", 32'h0, rd);
		reg_write(`PTPSQ_IDX_LOC_LAT, LAT);
		reg_write(`PTPSQ_IDX_PATH, 32'd5);
		reg_write(`PTPSQ_IDX_ASYM, ASYM);
		stamp_case(PTPSQ_EGRESS, PTPSQ_CMD_STAMP, 1'b0, 80'd1120, C0);
		stamp_case(PTPSQ_INGRESS, PTPSQ_CMD_STAMP, 1'b0, 80'd880, C0);
		reg_write(`PTPSQ_IDX_CTRL, 32'h0000_2010);
		w = 32'd0;
		stamp_case(PTPSQ_EGRESS, PTPSQ_CMD_CORR, 1'b0, 80'd0,
			C0 + (64'd1125 << 16) + SX);
		reg_write(`PTPSQ_IDX_CTRL, 32'h0000_4010);
		stamp_case(PTPSQ_INGRESS, PTPSQ_CMD_CORR, 1'b0, 80'd0,
			C0 - (64'd875 << 16) - SX);
		reg_write(`PTPSQ_IDX_CTRL, 32'h0000_0010);
		stamp_case(PTPSQ_EGRESS, PTPSQ_CMD_CORR, 1'b1, 80'd0,
			C0 + (64'd1125 << 16));
		n0 = got_cnt;
		calc(PTPSQ_EGRESS, 1'b0, PTPSQ_CMD_STAMP, 1'b1, 32'd1000);
		repeat (8) @(posedge clock);
		chk_reg("non_event", n0, got_cnt);
		chk_reg("ingress_store", 32'h0, st_n);
		// three signature bytes: two 13-byte entries fill one word
		reg_write(`PTPSQ_IDX_CTRL, 32'h0000_0003);
		calc(PTPSQ_EGRESS, 1'b1, PTPSQ_CMD_STAMP, 1'b1, 32'd1000);
		@(posedge clock);
		calc(PTPSQ_EGRESS, 1'b1, PTPSQ_CMD_STAMP, 1'b1, 32'd2000);
		repeat (6) @(posedge clock);
		reg_read(`PTPSQ_IDX_WORD0);
		chk_reg("sig3_w0", {4'h7, 12'h0, 16'd1120}, rd);
		reg_read(4'h3);
		chk_reg("sig3_w3", {8'h48, 24'hC3_0F1E}, rd);
		reg_read(`PTPSQ_IDX_POP);
		reg_read(`PTPSQ_IDX_WORD0);
		chk_reg("sig3_pop", 32'h1, {31'h0, rd[31]});
		chk_reg("stored_a", 32'd2, st_n);
		// short mode: seven 4-byte entries, threshold one
		reg_write(`PTPSQ_IDX_CTRL, 32'h0000_1120);
		for (i = 0; i < 7; i++) begin
			w = 32'h0101_0101 * (i + 1);
			pk[32*i +: 32] = w;
			calc(PTPSQ_EGRESS, 1'b1, PTPSQ_CMD_STAMP, 1'b1, w - 32'd120);
			@(posedge clock);
		end
		repeat (6) @(posedge clock);
		chk_reg("stored_b", 32'd9, st_n);
		reg_read(`PTPSQ_IDX_CTRL);
		chk_reg("level", 32'h1, {28'h0, rd[23:20]});
		chk_reg("thresh", 32'h1, {31'h0, te});
		reg_read(`PTPSQ_IDX_WORD0);
		chk_reg("short_w0", {4'h7, 12'h0, pk[15:0]}, rd);
		for (i = 1; i < 7; i++) begin
			reg_read(i[3:0]);
			chk_reg("short_wk", pk[32*i-16 +: 32], rd);
		end
		repeat (3) @(posedge clock);
		reg_read(`PTPSQ_IDX_WORD0);
		chk_reg("flush_w0", {16'h0, pk[223:208]}, rd);
		reg_read(`PTPSQ_IDX_POP);
		// depth two: the third word is dropped, rewriter stalls
		slow <= 1'b1;
		reg_write(`PTPSQ_IDX_CTRL, 32'h0000_0020);
		for (i = 0; i < 20; i++) begin
			calc(PTPSQ_EGRESS, 1'b1, PTPSQ_CMD_STAMP, 1'b1, 32'd1000 + i);
			@(posedge clock);
		end
		repeat (8) @(posedge clock);
		chk_reg("ovf_evt", 32'h1, ovf_n);
		reg_read(`PTPSQ_IDX_CTRL);
		chk_reg("ovf_lvl", 32'h8000_0002, {rd[31], 27'h0, rd[23:20]});
		reg_read(`PTPSQ_IDX_WORD0);
		chk_reg("ovf_keep", {4'h7, 12'h0, 16'd1120}, rd);
		reg_write(`PTPSQ_IDX_CTRL, 32'h0000_8020);
		reg_read(`PTPSQ_IDX_POP);
		chk_reg("serial_rd", 32'h0, rd);
		reg_read(`PTPSQ_IDX_CTRL);
		chk_reg("serial_lvl", 32'h2, {28'h0, rd[23:20]});
		reg_write(`PTPSQ_IDX_CTRL, 32'h0001_0020);
		reg_read(`PTPSQ_IDX_CTRL);
		chk_reg("ovf_clr", 32'h0, {31'h0, rd[31]});
		end_of_test();
	end
endmodule
`default_nettype wire
